// ==== dtb_consts.svh ====
// register offsets, field positions and reset values of the trim register bank
`ifndef DTB_CONSTS_SVH
`define DTB_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define DTB_ADDR_FIRST            8'h38
`define DTB_ADDR_LAST             8'h47
`define DTB_ADDR_I_PHASE_LOW      8'h38
`define DTB_ADDR_I_PHASE_HIGH     8'h39
`define DTB_ADDR_Q_PHASE_LOW      8'h3a
`define DTB_ADDR_Q_PHASE_HIGH     8'h3b
`define DTB_ADDR_I_OFFSET_LOW     8'h3c
`define DTB_ADDR_I_OFFSET_HIGH    8'h3d
`define DTB_ADDR_Q_OFFSET_LOW     8'h3e
`define DTB_ADDR_Q_OFFSET_HIGH    8'h3f
`define DTB_ADDR_I_TRIM_LOW       8'h40
`define DTB_ADDR_I_CONV_CTRL      8'h41
`define DTB_ADDR_I_AUX_LOW        8'h42
`define DTB_ADDR_I_AUX_CTRL       8'h43
`define DTB_ADDR_Q_TRIM_LOW       8'h44
`define DTB_ADDR_Q_CONV_CTRL      8'h45
`define DTB_ADDR_Q_AUX_LOW        8'h46
`define DTB_ADDR_Q_AUX_CTRL       8'h47

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DTB_HIGH_BITS_MSB         1
`define DTB_CONV_SLEEP_BIT        7
`define DTB_AUX_SIGN_BIT          7
`define DTB_AUX_SINK_BIT          6
`define DTB_AUX_SLEEP_BIT         5

// ----------------------------------------------------------------------------
// writable bit masks and reset values
// ----------------------------------------------------------------------------
`define DTB_MASK_FULL             8'hff
`define DTB_MASK_HIGH_BITS        8'h03
`define DTB_MASK_CONV_CTRL        8'h83
`define DTB_MASK_AUX_CTRL         8'he3
`define DTB_RESET_ZERO            8'h00
`define DTB_RESET_TRIM_LOW        8'hf9
`define DTB_RESET_CONV_CTRL       8'h01
`define DTB_REG_COUNT             16
`define DTB_READ_UNMAPPED         8'h00

`endif

// ==== dtb_pkg.sv ====
// types shared by the trim register bank
package dtb_pkg;
  typedef logic [7:0]  dtb_byte_t;
  typedef logic [3:0]  dtb_index_t;
  typedef logic [9:0]  dtb_code_t;
  typedef logic [15:0] dtb_sample_t;
endpackage

// ==== dtb_trim_bank.sv ====
// trim, offset and phase-correction register bank of a dual converter datapath
`timescale 1ns/1ps
`include "dtb_consts.svh"

module dtb_trim_bank
(
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  // byte port from the serial control port engine
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [7:0]         reg_rdata_o,
  output logic                    reg_rvalid_o,
  // sample stream
  input  wire logic [15:0]        i_sample_i,
  input  wire logic [15:0]        q_sample_i,
  input  wire logic               sample_valid_i,
  output logic      [15:0]        i_sample_o,
  output logic      [15:0]        q_sample_o,
  output logic                    sample_valid_o,
  // trim and control outputs
  output logic      [9:0]         i_phase_corr_o,
  output logic      [9:0]         q_phase_corr_o,
  output logic      [9:0]         i_full_scale_trim_o,
  output logic      [9:0]         q_full_scale_trim_o,
  output logic                    i_conv_sleep_o,
  output logic                    q_conv_sleep_o,
  output logic      [9:0]         i_aux_magnitude_o,
  output logic      [9:0]         q_aux_magnitude_o,
  output logic                    i_aux_to_neg_o,
  output logic                    i_aux_sink_o,
  output logic                    i_aux_sleep_o
);

  // --------------------------------------------------------------------------
  // decoding helpers
  // --------------------------------------------------------------------------
  function automatic dtb_pkg::dtb_index_t idx_of(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - `DTB_ADDR_FIRST;
    return diff[3:0];
  endfunction

  function automatic logic in_range(input logic [7:0] addr);
    return (addr >= `DTB_ADDR_FIRST) && (addr <= `DTB_ADDR_LAST);
  endfunction

  // unused bit positions are never stored, so they read back as zero
  function automatic dtb_pkg::dtb_byte_t bit_mask(input dtb_pkg::dtb_index_t idx);
    dtb_pkg::dtb_byte_t m;
    m = `DTB_MASK_FULL;
    if (idx == idx_of(`DTB_ADDR_I_PHASE_HIGH) || idx == idx_of(`DTB_ADDR_Q_PHASE_HIGH)
        || idx == idx_of(`DTB_ADDR_Q_AUX_CTRL))
      m = `DTB_MASK_HIGH_BITS;
    else if (idx == idx_of(`DTB_ADDR_I_CONV_CTRL) || idx == idx_of(`DTB_ADDR_Q_CONV_CTRL))
      m = `DTB_MASK_CONV_CTRL;
    else if (idx == idx_of(`DTB_ADDR_I_AUX_CTRL))
      m = `DTB_MASK_AUX_CTRL;
    return m;
  endfunction

  function automatic dtb_pkg::dtb_byte_t reset_val(input dtb_pkg::dtb_index_t idx);
    dtb_pkg::dtb_byte_t r;
    r = `DTB_RESET_ZERO;
    if (idx == idx_of(`DTB_ADDR_I_TRIM_LOW) || idx == idx_of(`DTB_ADDR_Q_TRIM_LOW))
      r = `DTB_RESET_TRIM_LOW;
    else if (idx == idx_of(`DTB_ADDR_I_CONV_CTRL) || idx == idx_of(`DTB_ADDR_Q_CONV_CTRL))
      r = `DTB_RESET_CONV_CTRL;
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  dtb_pkg::dtb_byte_t reg_file [`DTB_REG_COUNT];
  logic               wr_hit;
  dtb_pkg::dtb_index_t wr_idx;

  assign wr_hit = reg_wr_i && in_range(reg_addr_i);
  assign wr_idx = idx_of(reg_addr_i);

  genvar g;
  generate
    for (g = 0; g < `DTB_REG_COUNT; g++)
    begin : g_reg
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
          reg_file[g] <= reset_val(4'(g));
        else if (wr_hit && wr_idx == 4'(g))
          reg_file[g] <= reg_wdata_i & bit_mask(4'(g));
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // readback
  // --------------------------------------------------------------------------
  // a read in the same cycle as a write to that address sees the old value
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o  <= `DTB_READ_UNMAPPED;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= in_range(reg_addr_i) ? reg_file[idx_of(reg_addr_i)]
                                            : `DTB_READ_UNMAPPED;
    end
  end

  // --------------------------------------------------------------------------
  // sample offset
  // --------------------------------------------------------------------------
  // the sum wraps modulo 2^16; saturation is left to the converter path
  dtb_pkg::dtb_sample_t i_offset;
  dtb_pkg::dtb_sample_t q_offset;

  assign i_offset = {reg_file[idx_of(`DTB_ADDR_I_OFFSET_HIGH)],
                     reg_file[idx_of(`DTB_ADDR_I_OFFSET_LOW)]};
  assign q_offset = {reg_file[idx_of(`DTB_ADDR_Q_OFFSET_HIGH)],
                     reg_file[idx_of(`DTB_ADDR_Q_OFFSET_LOW)]};

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      i_sample_o     <= 16'h0000;
      q_sample_o     <= 16'h0000;
      sample_valid_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= sample_valid_i;
      i_sample_o     <= 16'(i_sample_i + i_offset);
      q_sample_o     <= 16'(q_sample_i + q_offset);
    end
  end

  // --------------------------------------------------------------------------
  // trim and control fields, straight from the register flops
  // --------------------------------------------------------------------------
  assign i_phase_corr_o = {reg_file[idx_of(`DTB_ADDR_I_PHASE_HIGH)][`DTB_HIGH_BITS_MSB:0],
                           reg_file[idx_of(`DTB_ADDR_I_PHASE_LOW)]};
  assign q_phase_corr_o = {reg_file[idx_of(`DTB_ADDR_Q_PHASE_HIGH)][`DTB_HIGH_BITS_MSB:0],
                           reg_file[idx_of(`DTB_ADDR_Q_PHASE_LOW)]};
  assign i_full_scale_trim_o = {reg_file[idx_of(`DTB_ADDR_I_CONV_CTRL)][`DTB_HIGH_BITS_MSB:0],
                                reg_file[idx_of(`DTB_ADDR_I_TRIM_LOW)]};
  assign q_full_scale_trim_o = {reg_file[idx_of(`DTB_ADDR_Q_CONV_CTRL)][`DTB_HIGH_BITS_MSB:0],
                                reg_file[idx_of(`DTB_ADDR_Q_TRIM_LOW)]};
  assign i_conv_sleep_o = reg_file[idx_of(`DTB_ADDR_I_CONV_CTRL)][`DTB_CONV_SLEEP_BIT];
  assign q_conv_sleep_o = reg_file[idx_of(`DTB_ADDR_Q_CONV_CTRL)][`DTB_CONV_SLEEP_BIT];
  assign i_aux_magnitude_o = {reg_file[idx_of(`DTB_ADDR_I_AUX_CTRL)][`DTB_HIGH_BITS_MSB:0],
                              reg_file[idx_of(`DTB_ADDR_I_AUX_LOW)]};
  assign q_aux_magnitude_o = {reg_file[idx_of(`DTB_ADDR_Q_AUX_CTRL)][`DTB_HIGH_BITS_MSB:0],
                              reg_file[idx_of(`DTB_ADDR_Q_AUX_LOW)]};
  assign i_aux_to_neg_o = reg_file[idx_of(`DTB_ADDR_I_AUX_CTRL)][`DTB_AUX_SIGN_BIT];
  assign i_aux_sink_o   = reg_file[idx_of(`DTB_ADDR_I_AUX_CTRL)][`DTB_AUX_SINK_BIT];
  assign i_aux_sleep_o  = reg_file[idx_of(`DTB_ADDR_I_AUX_CTRL)][`DTB_AUX_SLEEP_BIT];

endmodule // dtb_trim_bank

// ==== dtb_trim_bank_checker.sv ====
// assertion checker for the trim register bank
`timescale 1ns/1ps
module dtb_trim_bank_checker
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_rvalid_o,
  input  wire logic [15:0] i_sample_i,
  input  wire logic [15:0] i_sample_o,
  input  wire logic [9:0]  i_full_scale_trim_o,
  input  wire logic [9:0]  q_full_scale_trim_o,
  input  wire logic        i_conv_sleep_o,
  input  wire logic        q_conv_sleep_o,
  input  wire logic        i_aux_to_neg_o,
  input  wire logic        i_aux_sink_o,
  input  wire logic        i_aux_sleep_o
);
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic w41 = reg_wr_i && reg_addr_i == 8'h41;
  wire logic w45 = reg_wr_i && reg_addr_i == 8'h45;
  wire logic w43 = reg_wr_i && reg_addr_i == 8'h43;
  a_read_answer: assert property (1 |=> reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle after strobe");
  a_i_sleep_write: assert property (w41 |=> i_conv_sleep_o == $past(reg_wdata_i[7]))
    else $error("i sleep differs from written bit");
  a_q_sleep_write: assert property (w45 |=> q_conv_sleep_o == $past(reg_wdata_i[7]))
    else $error("q sleep differs from written bit");
  a_aux_sign_write: assert property (w43 |=> i_aux_to_neg_o == $past(reg_wdata_i[7]))
    else $error("aux sign differs from written bit");
  a_aux_sink_hold: assert property (!w43 |=> $stable(i_aux_sink_o))
    else $error("aux direction moved without a write");
  a_aux_sleep_write: assert property (w43 |=> i_aux_sleep_o == $past(reg_wdata_i[5]))
    else $error("aux sleep differs from written bit");
  // any write may touch the offset, so only idle stretches are compared;
  // the first edge after reset is skipped because the output is still cleared
  a_offset_steady: assert property (!reg_wr_i && !$past(rst_i) ##1 !reg_wr_i |=>
    i_sample_o - $past(i_sample_i) == $past(i_sample_o) - $past(i_sample_i, 2))
    else $error("i offset changed without a write");
  a_trim_reset_value: assert property ($fell(rst_i) |->
    i_full_scale_trim_o == 10'h1f9 && q_full_scale_trim_o == 10'h1f9)
    else $error("trim not at reset value");
endmodule // dtb_trim_bank_checker

bind dtb_trim_bank dtb_trim_bank_checker u_chk (.*);

// ==== dtb_trim_bank_tb_top.sv ====
// self-checking testbench of the trim register bank
`timescale 1ns/1ps
module dtb_trim_bank_tb_top;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [15:0] i_sample_i = 16'h0000;
  logic [15:0] q_sample_i = 16'h0000;
  logic        sample_valid_i = 1'b0;
  logic [7:0]  reg_rdata_o, e_rd;
  logic [15:0] i_sample_o, q_sample_o, e_si, e_sq;
  logic [9:0]  i_phase_corr_o, q_phase_corr_o, i_full_scale_trim_o, q_full_scale_trim_o;
  logic [9:0]  i_aux_magnitude_o, q_aux_magnitude_o;
  logic        reg_rvalid_o, sample_valid_o, e_rv, e_sv;
  logic        i_conv_sleep_o, q_conv_sleep_o, i_aux_to_neg_o, i_aux_sink_o, i_aux_sleep_o;
  logic [7:0]  m [16];
  int          bad_count = 0;
  int          checks_done = 0;

  dtb_trim_bank dut (.*);

  initial forever #50 sys_clk_i = ~sys_clk_i;

  // --------------------
  // model and checks
  // --------------------
  function automatic logic [7:0] msk(int i);
    case (i)
      1, 3, 15: msk = 8'h03;
      9, 13:    msk = 8'h83;
      11:       msk = 8'he3;
      default:  msk = 8'hff;
    endcase
  endfunction

  function automatic logic [9:0] f10(int i);
    f10 = {m[i+1][1:0], m[i]};
  endfunction

  task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmp_flag(string n, logic e, logic s);
    cmp(n, 16'(e), 16'(s));
  endtask

  task automatic cmp_byte(string n, logic [7:0] e, logic [7:0] s);
    cmp(n, 16'(e), 16'(s));
  endtask

  task automatic cmp_code(string n, logic [9:0] e, logic [9:0] s);
    cmp(n, 16'(e), 16'(s));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (m[k]) m[k] = 8'h00;
    m[8] = 8'hf9;
    m[12] = 8'hf9;
    m[9] = 8'h01;
    m[13] = 8'h01;
    {e_rd, e_rv, e_sv, e_si, e_sq} = '0;
  endtask

  // unmapped 0x36, 0x37, 0x48 and 0x49 are mixed in to see them refused
  task automatic step(bit wr_on);
    int a;
    @(posedge sys_clk_i);
    a = reg_addr_i - 8'h38;
    e_sv = sample_valid_i;
    e_si = i_sample_i + {m[5], m[4]};
    e_sq = q_sample_i + {m[7], m[6]};
    e_rv = reg_rd_i;
    if (reg_rd_i) e_rd = (a >= 0 && a < 16) ? m[a] : 8'h00;
    if (reg_wr_i && a >= 0 && a < 16) m[a] = reg_wdata_i & msk(a);
    reg_addr_i <= 8'h36 + 8'($urandom % 20);
    reg_wdata_i <= 8'($urandom);
    reg_wr_i <= wr_on & 1'($urandom);
    reg_rd_i <= 1'($urandom);
    i_sample_i <= 16'($urandom);
    q_sample_i <= 16'($urandom);
    sample_valid_i <= 1'($urandom);
    @(negedge sys_clk_i);
    cmp_flag("rvalid", e_rv, reg_rvalid_o);
    cmp_byte("rdata", e_rd, reg_rdata_o);
    cmp_flag("svalid", e_sv, sample_valid_o);
    cmp("i_sample", e_si, i_sample_o);
    cmp("q_sample", e_sq, q_sample_o);
    cmp_code("i_phase", f10(0), i_phase_corr_o);
    cmp_code("q_phase", f10(2), q_phase_corr_o);
    cmp_code("i_trim", f10(8), i_full_scale_trim_o);
    cmp_code("q_trim", f10(12), q_full_scale_trim_o);
    cmp_code("i_aux", f10(10), i_aux_magnitude_o);
    cmp_code("q_aux", f10(14), q_aux_magnitude_o);
    cmp_flag("i_sleep", m[9][7], i_conv_sleep_o);
    cmp_flag("q_sleep", m[13][7], q_conv_sleep_o);
    cmp_flag("aux_sign", m[11][7], i_aux_to_neg_o);
    cmp_flag("aux_sink", m[11][6], i_aux_sink_o);
    cmp_flag("aux_sleep", m[11][5], i_aux_sleep_o);
  endtask

  initial
  begin
    void'($urandom(32'hccf15ac2));
    do_reset();
    repeat (40) step(1'b0);
    repeat (600) step(1'b1);
    do_reset();
    repeat (40) step(1'b0);
    repeat (200) step(1'b1);
    give_verdict();
  end
endmodule // dtb_trim_bank_tb_top
